// File: dv/hbp_host.sv
//----------------------------------------------------------------
// Purpose : Host CPU with decode and strobe glue
// Assumes : stb_n is {high read, low read, high byte, low write}
// Notes   : A released data bus shows the inverse of its last value
//----------------------------------------------------------------
`timescale 1ns/1ps
module hbp_host (
	input  wire logic        mclk,
	input  wire logic        m2,
	input  wire logic        wait_n,
	input  wire logic        oe,
	input  wire logic [15:0] dout,
	output logic             cs_n,
	output logic [3:0]       stb_n,
	output logic [16:0]      addr,
	output logic [15:0]      data
);
	// Idle bus at time zero
	initial begin
		cs_n = 1'b1;
		stb_n = 4'hF;
		addr = 17'h0_0000;
		data = 16'h0000;
	end

	// One access; lanes ln = {high, low}
	task automatic acc(input logic wr, input logic [1:0] ln, input logic [16:0] a,
		input logic [15:0] wd, output logic [15:0] rd, output logic ok);
		int n;
		@(posedge mclk);
		cs_n <= 1'b0;
		addr <= a;
		data <= wr ? wd : ~data;
		if (m2)
			stb_n <= {1'b1, wr, ~ln[1], ~wr};
		else
			stb_n <= wr ? {2'b11, ~ln[1], ~ln[0]} : {~ln[1], ~ln[0], 2'b11};
		n = 0;
		do begin @(posedge mclk); n++; end while (wait_n !== 1'b0 && n < 8);
		ok = (wait_n === 1'b0);
		n = 0;
		// Stretch the cycle while wait is low
		do begin @(posedge mclk); n++; end while (wait_n !== 1'b1 && n < 80);
		ok = ok && (wait_n === 1'b1);
		rd = dout;
		cs_n <= 1'b1;
		stb_n <= 4'hF;
		data <= ~data;
		n = 0;
		do begin @(posedge mclk); n++; end while (oe !== 1'b0 && n < 8);
		repeat (3) @(posedge mclk);
	endtask : acc

	// Strobes that must not start an access; seen = wait went low
	task automatic stray(input logic c, input logic [3:0] s, output logic seen);
		@(posedge mclk);
		cs_n <= c;
		stb_n <= s;
		addr <= 17'h0_0000;
		data <= 16'hFFFF;
		seen = 1'b0;
		repeat (8) begin @(posedge mclk); seen = seen | (wait_n !== 1'b1); end
		cs_n <= 1'b1;
		stb_n <= 4'hF;
		data <= 16'h0000;
		repeat (4) @(posedge mclk);
	endtask : stray
endmodule : hbp_host

// File: dv/hbp_port_monitor.sv
//----------------------------------------------------------------
// Purpose : Port checks for the generic host bus port
// Assumes : One clock mclk, rst async active high
// Notes   : Host holds cs and strobes until it sees wait_n high
//----------------------------------------------------------------
`timescale 1ns/1ps
module hbp_port_monitor (
	input wire logic mclk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic low_write_strobe_n,
	input wire logic high_byte_strobe_n,
	input wire logic low_read_strobe_n,
	input wire logic high_read_strobe_n,
	input wire logic host_data_oe,
	input wire logic wait_n,
	input wire logic refresh_req,
	input wire logic generic_second,
	input wire logic port_enabled,
	input wire logic big_endian
);
	// Request kinds; second mode has one strobe per direction
	wire rd_any = !low_read_strobe_n || (!high_read_strobe_n && !generic_second);
	wire wr_any = !low_write_strobe_n || (!high_byte_strobe_n && !generic_second);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// No refresh over the whole wait, so no arbitration stall
	sequence s_quiet;
		$fell(wait_n) ##0 (!refresh_req)[*4];
	endsequence
	sequence s_start;
		port_enabled && $fell(cs_n) && (rd_any != wr_any);
	endsequence

	a_idle_when_off: assert property (!port_enabled |-> wait_n && !host_data_oe)
		else $error("wait or drive while port disabled");
	a_straps_hold: assert property (port_enabled |=> port_enabled &&
		$stable(big_endian) && $stable(generic_second))
		else $error("latched straps changed");
	a_wait_exact: assert property (s_quiet |-> wait_n && !$past(wait_n) &&
		!$past(wait_n, 2))
		else $error("wait low not three cycles");
	a_wait_latency: assert property (s_start |-> ##[2:4] !wait_n)
		else $error("no wait after request");
	a_both_ignored: assert property (port_enabled && $fell(cs_n) && rd_any &&
		wr_any |-> wait_n[*6])
		else $error("read and write together taken");
	a_oe_on_read: assert property ($rose(host_data_oe) |-> $rose(wait_n) &&
		!cs_n && rd_any)
		else $error("drive without read answer");
	a_oe_release: assert property ($rose(cs_n) |-> ##[1:4] !host_data_oe)
		else $error("data bus held after release");
	a_no_select: assert property (cs_n[*5] |-> wait_n && !host_data_oe)
		else $error("activity without select");
endmodule : hbp_port_monitor

bind hbp_port hbp_port_monitor u_mon (.mclk(mclk), .rst(rst), .cs_n(cs_n),
	.low_write_strobe_n(low_write_strobe_n), .high_byte_strobe_n(high_byte_strobe_n),
	.low_read_strobe_n(low_read_strobe_n), .high_read_strobe_n(high_read_strobe_n),
	.host_data_oe(host_data_oe), .wait_n(wait_n), .refresh_req(refresh_req),
	.generic_second(generic_second), .port_enabled(port_enabled),
	.big_endian(big_endian));

// File: dv/testbench.sv
//----------------------------------------------------------------
// Purpose : Self-checking bench for the generic host bus port
// Assumes : Memory keeps its contents across resets
// Notes   : Mode and endian change only through a new reset
//----------------------------------------------------------------
`timescale 1ns/1ps
module testbench;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [2:0]  mode = 3'h0;
	logic        bs_n = 1'b0;
	logic        endn = 1'b0;
	logic        rreq = 1'b0;
	logic [15:0] raddr = 16'h0000;
	logic        cs_n, wait_n, oe, rack, gsec, pen, bige, seen;
	logic [3:0]  stb_n;
	logic [16:0] addr;
	logic [15:0] hdata, dout, rdata;
	int          err_total = 0;
	int          checks = 0;

	initial forever #5 mclk = ~mclk;

	// Data bus as seen by the device: its own drive wins when enabled
	wire [15:0] hin = oe ? dout : hdata;

	hbp_host host (.mclk(mclk), .m2(gsec), .wait_n(wait_n), .oe(oe), .dout(dout),
		.cs_n(cs_n), .stb_n(stb_n), .addr(addr), .data(hdata));

	hbp_port uut (.mclk(mclk), .rst(rst), .ce(1'b1), .mode_select_pins(mode),
		.bus_start_n(bs_n), .endian_select_pin(endn), .cs_n(cs_n),
		.low_write_strobe_n(stb_n[0]), .high_byte_strobe_n(stb_n[1]),
		.low_read_strobe_n(stb_n[2]), .high_read_strobe_n(stb_n[3]), .host_addr(addr),
		.host_data_in(hin), .host_data_out(dout), .host_data_oe(oe), .wait_n(wait_n),
		.refresh_req(rreq), .refresh_addr(raddr), .refresh_data(rdata),
		.refresh_ack(rack), .generic_second(gsec), .port_enabled(pen),
		.big_endian(bige));

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask : chk

	// Reset with new straps, then check what was latched
	task automatic cfg(input logic [2:0] m, input logic b, input logic e);
		mode <= m;
		bs_n <= b;
		endn <= e;
		rst <= 1'b1;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		repeat (8) @(posedge mclk);
		chk("enabled", {15'h0, m == 3'h7}, {15'h0, pen});
		chk("second", {15'h0, b}, {15'h0, gsec});
		chk("big", {15'h0, e}, {15'h0, bige});
	endtask : cfg

	// One access; a read compares under mask k
	task automatic xfer(input logic w, input logic [1:0] ln, input logic [16:0] a,
		input logic [15:0] d, input logic [15:0] k);
		logic [15:0] got;
		logic ok;
		host.acc(w, ln, a, d, got, ok);
		chk("done", 16'h0001, {15'h0, ok});
		if (!w)
			chk("rdata", d & k, got & k);
	endtask : xfer

	task automatic wrap_up;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up

	//----------------------------------------------------------------
	// Test sequence
	//----------------------------------------------------------------
	initial begin
		cfg(3'h7, 1'b0, 1'b0);
		xfer(1'b1, 2'b11, 17'h0_0000, 16'h1234, 16'hFFFF);
		xfer(1'b0, 2'b11, 17'h0_0000, 16'h1234, 16'hFFFF);
		xfer(1'b1, 2'b01, 17'h0_0000, 16'h00AB, 16'hFFFF);
		xfer(1'b0, 2'b10, 17'h0_0000, 16'h1200, 16'hFF00);
		xfer(1'b1, 2'b11, 17'h1_3FFE, 16'h5A5A, 16'hFFFF);
		xfer(1'b0, 2'b11, 17'h1_3FFE, 16'h5A5A, 16'hFFFF);
		xfer(1'b1, 2'b11, 17'h1_4000, 16'h7777, 16'hFFFF);
		xfer(1'b0, 2'b11, 17'h1_4000, 16'h0000, 16'hFFFF);
		xfer(1'b1, 2'b11, 17'h1_FFE0, 16'h00C3, 16'hFFFF);
		xfer(1'b1, 2'b11, 17'h1_FFFE, 16'hA55A, 16'hFFFF);
		xfer(1'b0, 2'b11, 17'h1_FFE0, 16'h00C3, 16'hFFFF);
		xfer(1'b0, 2'b11, 17'h1_FFFE, 16'hA55A, 16'hFFFF);
		xfer(1'b0, 2'b11, 17'h1_FFDE, 16'h0000, 16'hFFFF);
		$display("test map done");
		host.stray(1'b1, 4'b1100, seen);
		chk("no select", 16'h0000, {15'h0, seen});
		host.stray(1'b0, 4'b0000, seen);
		chk("both dirs", 16'h0000, {15'h0, seen});
		xfer(1'b0, 2'b11, 17'h0_0000, 16'h12AB, 16'hFFFF);
		$display("test stray done");
		// Refresh holds the host off until it lets go
		rreq <= 1'b1;
		fork
			xfer(1'b0, 2'b11, 17'h0_0000, 16'h12AB, 16'hFFFF);
			begin
				repeat (12) @(posedge mclk);
				chk("stall", 16'h0000, {15'h0, wait_n});
				chk("ack", 16'h0001, {15'h0, rack});
				chk("refresh", 16'h12AB, rdata);
				rreq <= 1'b0;
			end
		join
		$display("test refresh done");
		cfg(3'h7, 1'b1, 1'b1);
		xfer(1'b0, 2'b11, 17'h0_0000, 16'hAB12, 16'hFFFF);
		xfer(1'b0, 2'b11, 17'h1_FFE0, 16'h0000, 16'hFFFF);
		xfer(1'b1, 2'b10, 17'h0_0001, 16'h3300, 16'hFFFF);
		xfer(1'b1, 2'b01, 17'h0_0000, 16'h0044, 16'hFFFF);
		xfer(1'b0, 2'b11, 17'h0_0000, 16'h3344, 16'hFFFF);
		$display("test second mode done");
		// Same bytes seen through the other mode and endian pairs
		cfg(3'h7, 1'b0, 1'b1);
		xfer(1'b0, 2'b11, 17'h0_0000, 16'h3344, 16'hFFFF);
		xfer(1'b1, 2'b01, 17'h0_0000, 16'h0055, 16'hFFFF);
		xfer(1'b0, 2'b11, 17'h0_0000, 16'h3355, 16'hFFFF);
		cfg(3'h7, 1'b1, 1'b0);
		xfer(1'b0, 2'b11, 17'h0_0000, 16'h5533, 16'hFFFF);
		xfer(1'b1, 2'b10, 17'h0_0001, 16'h6600, 16'hFFFF);
		xfer(1'b0, 2'b11, 17'h0_0000, 16'h6633, 16'hFFFF);
		$display("test lane order done");
		// Straps still latched while the port stays off
		cfg(3'h5, 1'b1, 1'b1);
		host.stray(1'b0, 4'b1011, seen);
		chk("off mode", 16'h0000, {15'h0, seen});
		$display("test off mode done");
		wrap_up();
	end

	// Hang guard, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		wrap_up();
	end
endmodule : testbench

// File: pkg/hbp_pkg.sv
//------------------------------------------------------------------------------
// Purpose : Constants, pin bundle and helpers for the generic host bus port
// Assumes : 16-bit host data bus, 17-bit byte address window
// Notes   : Used by the port core, which sizes and resets its synchroniser from it
//------------------------------------------------------------------------------
package hbp_pkg;

	//--------------------------------------------------------------------------
	// Widths and address map
	//--------------------------------------------------------------------------
	localparam int          ADDR_W      = 17;
	localparam int          DATA_W      = 16;
	localparam int          MODE_W      = 3;
	localparam logic [16:0] MEM_LAST    = 17'h1_3FFF;   // Last display memory byte
	localparam logic [16:0] REG_FIRST   = 17'h1_FFE0;   // First register byte
	localparam int          MEM_WORDS   = 40960;        // Display memory, 16-bit words
	localparam int          REG_WORDS   = 16;           // 32 register bytes
	localparam int          REG_IDX_W   = 4;
	localparam int          MEM_IDX_W   = 16;

	//--------------------------------------------------------------------------
	// Strap decoding and start-up timing
	//--------------------------------------------------------------------------
	localparam logic [2:0]  MODE_GENERIC = 3'h7;        // Mode pins all ones
	localparam logic [1:0]  CFG_SETTLE   = 2'h3;        // Edges before straps latch
	localparam logic [1:0]  CFG_STEP     = 2'h1;
	localparam logic [15:0] DATA_ZERO    = 16'h0000;
	localparam logic [15:0] REG_RST_VAL  = 16'h0000;

	//--------------------------------------------------------------------------
	// Pins as seen after synchronisation
	//--------------------------------------------------------------------------
	typedef struct packed {
		logic              cs_n;
		logic              low_write_strobe_n;
		logic              high_byte_strobe_n;
		logic              low_read_strobe_n;
		logic              high_read_strobe_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [MODE_W-1:0] mode_select_pins;
		logic              bus_start_n;
		logic              endian_select_pin;
	} hbp_pins_t;

	localparam int        PINS_W       = $bits(hbp_pins_t);
	// Select and strobes idle high, everything else low
	localparam hbp_pins_t PINS_RST_VAL = '{cs_n: 1'b1, low_write_strobe_n: 1'b1,
		high_byte_strobe_n: 1'b1, low_read_strobe_n: 1'b1, high_read_strobe_n: 1'b1,
		addr: 17'h0_0000, data: 16'h0000, mode_select_pins: 3'h0, bus_start_n: 1'b0,
		endian_select_pin: 1'b0};

	// Swap the two byte lanes of a word
	function automatic logic [15:0] swap16(input logic [15:0] w);
		swap16 = {w[7:0], w[15:8]};
	endfunction : swap16

	// Reorder a word between bus and memory lane order
	function automatic logic [15:0] lane_order(input logic big, input logic [15:0] w);
		lane_order = big ? swap16(w) : w;
	endfunction : lane_order

endpackage : hbp_pkg

// File: verilog/hbp_port.sv
//------------------------------------------------------------------------------
// Purpose : Generic 16-bit host bus port with wait, display memory and registers
// Assumes : mclk is the host port clock; strobes are asynchronous to it
// Notes   : Display refresh reads share the memory and win arbitration
//------------------------------------------------------------------------------
// Function
// - Straps latched after reset; mode pins 111 pick generic mode, bus start high picks second mode.
// - Endian pin latched after reset: high big-endian, low little-endian bus lanes.
// - Port takes a 17-bit byte address and a 16-bit two-way data bus.
// - Byte addresses zero to 13FFFh reach the display memory.
// - Byte addresses 1FFE0h to 1FFFFh reach the 32-byte register set.
// - Only 128K window decoded; higher host bits ignored, so device aliases.
// - Wait held low until read data valid or write data taken.
// - Control strobes are asynchronous and synchronised inside the port.
// - Port and its refresh interface both run from the one clock mclk.
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
module hbp_port #(
	parameter int MEM_WORDS = hbp_pkg::MEM_WORDS,
	parameter int REG_WORDS = hbp_pkg::REG_WORDS
) (
	input  wire logic                            mclk,
	input  wire logic                            rst,
	input  wire logic                            ce,
	input  wire logic [hbp_pkg::MODE_W-1:0]      mode_select_pins,
	input  wire logic                            bus_start_n,
	input  wire logic                            endian_select_pin,
	input  wire logic                            cs_n,
	input  wire logic                            low_write_strobe_n,
	input  wire logic                            high_byte_strobe_n,
	input  wire logic                            low_read_strobe_n,
	input  wire logic                            high_read_strobe_n,
	input  wire logic [hbp_pkg::ADDR_W-1:0]      host_addr,
	input  wire logic [hbp_pkg::DATA_W-1:0]      host_data_in,
	output logic      [hbp_pkg::DATA_W-1:0]      host_data_out,
	output logic                                 host_data_oe,
	output logic                                 wait_n,
	input  wire logic                            refresh_req,
	input  wire logic [hbp_pkg::MEM_IDX_W-1:0]   refresh_addr,
	output logic      [hbp_pkg::DATA_W-1:0]      refresh_data,
	output logic                                 refresh_ack,
	output logic                                 generic_second,
	output logic                                 port_enabled,
	output logic                                 big_endian
);

	//--------------------------------------------------------------------------
	// Synchronised pins
	//--------------------------------------------------------------------------
	hbp_pkg::hbp_pins_t pins_raw;
	hbp_pkg::hbp_pins_t pins;

	assign pins_raw = '{cs_n: cs_n, low_write_strobe_n: low_write_strobe_n,
		high_byte_strobe_n: high_byte_strobe_n, low_read_strobe_n: low_read_strobe_n,
		high_read_strobe_n: high_read_strobe_n, addr: host_addr, data: host_data_in,
		mode_select_pins: mode_select_pins, bus_start_n: bus_start_n,
		endian_select_pin: endian_select_pin};

	// Host may clock its strobes from anything, so all pins cross here
	hbp_sync #(
		.W       (hbp_pkg::PINS_W),
		.RST_VAL (hbp_pkg::PINS_RST_VAL)
	) u_sync (
		.mclk (mclk),
		.rst  (rst),
		.ce   (ce),
		.d    (pins_raw),
		.q    (pins)
	);

	//--------------------------------------------------------------------------
	// Strap capture
	//--------------------------------------------------------------------------
	logic [1:0] cfg_cnt_r;
	logic       cfg_done_r;
	logic       mode_ok_r;
	logic       second_r;
	logic       big_r;
	wire        cfg_take = !cfg_done_r && (cfg_cnt_r == hbp_pkg::CFG_SETTLE);

	// Straps caught only after the synchroniser has filled, never under reset
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cfg_cnt_r  <= 2'h0;
			cfg_done_r <= 1'b0;
			mode_ok_r  <= 1'b0;
			second_r   <= 1'b0;
			big_r      <= 1'b0;
		end else if (ce) begin
			if (!cfg_done_r && !cfg_take) begin
				cfg_cnt_r <= cfg_cnt_r + hbp_pkg::CFG_STEP;
			end
			if (cfg_take) begin
				cfg_done_r <= 1'b1;
				mode_ok_r  <= (pins.mode_select_pins == hbp_pkg::MODE_GENERIC);
				second_r   <= pins.bus_start_n;
				big_r      <= pins.endian_select_pin;
			end
		end
	end

	//--------------------------------------------------------------------------
	// Strobe decode per mode
	//--------------------------------------------------------------------------
	wire sel      = !pins.cs_n;
	wire first_rd = !pins.low_read_strobe_n || !pins.high_read_strobe_n;
	wire first_wr = !pins.low_write_strobe_n || !pins.high_byte_strobe_n;
	wire sec_rd   = !pins.low_read_strobe_n;
	wire sec_wr   = !pins.low_write_strobe_n;
	wire acc_rd   = second_r ? sec_rd : first_rd;
	wire acc_wr   = second_r ? sec_wr : first_wr;
	// Both directions at once is treated as no access
	wire acc_req  = mode_ok_r && sel && (acc_rd ^ acc_wr);

	// Bus lane enables: per-strobe in first mode, A0 and high enable in second
	wire bus_hi   = second_r ? !pins.high_byte_strobe_n
	              : (acc_rd ? !pins.high_read_strobe_n : !pins.high_byte_strobe_n);
	wire bus_lo   = second_r ? !pins.addr[0]
	              : (acc_rd ? !pins.low_read_strobe_n : !pins.low_write_strobe_n);
	// Big-endian hosts put the even byte on the high lane
	wire mem_hi   = big_r ? bus_lo : bus_hi;
	wire mem_lo   = big_r ? bus_hi : bus_lo;
	wire [15:0] wr_word = hbp_pkg::lane_order(big_r, pins.data);

	//--------------------------------------------------------------------------
	// Address decode inside the 128K window
	//--------------------------------------------------------------------------
	// Only the 17 address pins exist, so the window repeats above them
	wire hit_mem  = (pins.addr <= hbp_pkg::MEM_LAST);
	wire hit_reg  = (pins.addr >= hbp_pkg::REG_FIRST);
	wire [hbp_pkg::MEM_IDX_W-1:0] mem_idx = pins.addr[16:1];
	wire [hbp_pkg::REG_IDX_W-1:0] reg_idx = pins.addr[4:1];

	//--------------------------------------------------------------------------
	// Access sequencer
	//--------------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ARB,
		ST_DO,
		ST_RESP,
		ST_HOLD
	} hbp_state_t;

	hbp_state_t state_r;
	hbp_state_t state_nxt;
	logic       is_rd_r;
	logic       hit_mem_r;
	logic       hit_reg_r;

	// Refresh takes the memory whenever the host is not in its access cycle
	wire rf_serve = refresh_req && (state_r != ST_DO);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (acc_req) begin
					state_nxt = ST_ARB;
				end
			end
			ST_ARB: begin
				if (!acc_req) begin
					state_nxt = ST_IDLE;              // Strobe withdrawn
				end else if (!refresh_req) begin
					state_nxt = ST_DO;
				end
			end
			ST_DO: begin
				state_nxt = ST_RESP;
			end
			ST_RESP: begin
				state_nxt = ST_HOLD;
			end
			ST_HOLD: begin
				if (!acc_req) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_r   <= ST_IDLE;
			is_rd_r   <= 1'b0;
			hit_mem_r <= 1'b0;
			hit_reg_r <= 1'b0;
		end else if (ce) begin
			state_r <= state_nxt;
			if (state_r == ST_DO) begin
				is_rd_r   <= acc_rd;
				hit_mem_r <= hit_mem;
				hit_reg_r <= hit_reg;
			end
		end
	end

	//--------------------------------------------------------------------------
	// Display memory: one read port shared with refresh
	//--------------------------------------------------------------------------
	logic [15:0] mem [MEM_WORDS];
	logic [15:0] mem_q_r;
	wire         host_go = (state_r == ST_DO);
	wire [hbp_pkg::MEM_IDX_W-1:0] rd_idx = host_go ? mem_idx : refresh_addr;

	// No reset on the array; its contents are undefined after power-up
	always_ff @(posedge mclk) begin
		if (ce) begin
			mem_q_r <= mem[rd_idx];
			if (host_go && acc_wr && hit_mem && mem_hi) begin
				mem[mem_idx][15:8] <= wr_word[15:8];
			end
			if (host_go && acc_wr && hit_mem && mem_lo) begin
				mem[mem_idx][7:0] <= wr_word[7:0];
			end
		end
	end

	//--------------------------------------------------------------------------
	// Register set, byte writable
	//--------------------------------------------------------------------------
	logic [15:0] regs_r [REG_WORDS];
	logic [15:0] reg_q_r;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < REG_WORDS; i++) begin
				regs_r[i] <= hbp_pkg::REG_RST_VAL;
			end
			reg_q_r <= hbp_pkg::DATA_ZERO;
		end else if (ce && host_go) begin
			reg_q_r <= regs_r[reg_idx];
			if (acc_wr && hit_reg && mem_hi) begin
				regs_r[reg_idx][15:8] <= wr_word[15:8];
			end
			if (acc_wr && hit_reg && mem_lo) begin
				regs_r[reg_idx][7:0] <= wr_word[7:0];
			end
		end
	end

	//--------------------------------------------------------------------------
	// Host data and wait outputs
	//--------------------------------------------------------------------------
	// Unmapped reads inside the window return zero
	wire [15:0] rd_word = hit_mem_r ? mem_q_r : (hit_reg_r ? reg_q_r : hbp_pkg::DATA_ZERO);
	wire        wait_nxt = !((state_nxt == ST_ARB) || (state_nxt == ST_DO)
	                     || (state_nxt == ST_RESP));

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			host_data_out <= hbp_pkg::DATA_ZERO;
			host_data_oe  <= 1'b0;
			wait_n        <= 1'b1;
		end else if (ce) begin
			wait_n <= wait_nxt;
			if (state_r == ST_RESP) begin
				host_data_out <= hbp_pkg::lane_order(big_r, rd_word);
			end
			host_data_oe <= (state_nxt == ST_HOLD) && is_rd_r;
		end
	end

	//--------------------------------------------------------------------------
	// Refresh answer and status outputs
	//--------------------------------------------------------------------------
	logic rf_srv_r;

	// Data stands two edges after the served request, with the ack
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rf_srv_r       <= 1'b0;
			refresh_ack    <= 1'b0;
			refresh_data   <= hbp_pkg::DATA_ZERO;
			generic_second <= 1'b0;
			port_enabled   <= 1'b0;
			big_endian     <= 1'b0;
		end else if (ce) begin
			rf_srv_r    <= rf_serve;
			refresh_ack <= rf_srv_r;
			if (rf_srv_r) begin
				refresh_data <= mem_q_r;
			end
			generic_second <= second_r;
			port_enabled   <= mode_ok_r;
			big_endian     <= big_r;
		end
	end

endmodule : hbp_port

// File: verilog/hbp_sync.sv
//------------------------------------------------------------------------------
// Purpose : Two-flop synchroniser for a bundle of host pins
// Assumes : Each bit is a level that is stable while it matters
// Notes   : First stage is read by the second stage only
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module hbp_sync #(
	parameter int               W       = 1,
	parameter logic [W-1:0]     RST_VAL = '0
) (
	input  wire logic           mclk,
	input  wire logic           rst,
	input  wire logic           ce,
	input  wire logic [W-1:0]   d,
	output logic      [W-1:0]   q
);

	logic [W-1:0] meta_r;

	//--------------------------------------------------------------------------
	// Two stages, held by the clock enable
	//--------------------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta_r <= RST_VAL;
			q      <= RST_VAL;
		end else if (ce) begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule : hbp_sync
